// ===== hw/etd0_params.svh
// offsets, field positions, reset values and sizes of the transmit descriptor engine
`ifndef ETD0_PARAMS_SVH
`define ETD0_PARAMS_SVH
`define ETD0_OFS_CTRL 8'h00
`define ETD0_OFS_BASE 8'h04
`define ETD0_OFS_STAT 8'h08
`define ETD0_OFS_CUR 8'h0c
`define ETD0_CTRL_RUN 0
`define ETD0_CTRL_POLL 1
`define ETD0_STAT_TXIRQ 0
`define ETD0_STAT_UNAVAIL 1
`define ETD0_BASE_RST 32'h0000_0000
`define ETD0_DESC_WORDS 8
`define ETD0_DESC_BYTES 32'h0000_0020
`define ETD0_B_OWN 31
`define ETD0_B_IRQ 30
`define ETD0_B_LAST 29
`define ETD0_B_FIRST 28
`define ETD0_B_NOCRC 27
`define ETD0_B_NOPAD 26
`define ETD0_B_STAMP 25
`define ETD0_B_CRCOVR 24
`define ETD0_F_CSUM_HI 23
`define ETD0_F_CSUM_LO 22
`define ETD0_B_WRAP 21
`define ETD0_B_CHAIN 20
`define ETD0_F_VLAN_HI 19
`define ETD0_F_VLAN_LO 18
`define ETD0_B_STAMPED 17
`define ETD0_B_ERRSUM 15
`define ETD0_ERR_MASK 32'h0001_7f06
`define ETD0_STATUS_MASK 32'h0001_ffff
`define ETD0_F_SIZE1_HI 12
`define ETD0_F_SIZE2_LO 16
`define ETD0_F_SIZE2_HI 28
`define ETD0_RESP_OKAY 2'b00
`define ETD0_RESP_DECERR 2'b11
`endif

// ===== hw/etd0_pkg.sv
// types of the transmit descriptor engine
package etd0_pkg;
   typedef logic [7:0][31:0] etd0_desc_type;
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_FETCH = 8'h02,
      ST_DESC = 8'h04,
      ST_SEG = 8'h08,
      ST_DRAIN = 8'h10,
      ST_FRAME = 8'h20,
      ST_WB = 8'h40,
      ST_SUSPEND = 8'h80
   } etd0_state_type;
   typedef struct packed {
      logic append_crc;
      logic pad_enable;
      logic crc_replace;
      logic stamp_req;
      logic [1:0] csum_sel;
      logic [1:0] vlan_action;
   } etd0_frame_ctl_type;
   typedef struct packed {
      logic first;
      logic last;
      logic [31:0] buf1_addr;
      logic [12:0] buf1_size;
      logic [31:0] buf2_addr;
      logic [12:0] buf2_size;
   } etd0_seg_type;
   typedef struct packed {
      logic [31:0] status;
      logic stamp_valid;
      logic [63:0] stamp;
   } etd0_done_type;
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] word0;
      logic stamp_en;
      logic [31:0] word2;
      logic [31:0] word3;
   } etd0_wb_type;
endpackage : etd0_pkg

// ===== hw/etd0_top.sv
// transmit descriptor engine: fetch, decode, segment hand-off, status write-back
//
// Summary of operation
// - a descriptor is eight words, fetched together
// - own bit set: engine may process it
// - engine clears own after frame or buffers drained
// - irq_on_done plus last sets transmit interrupt status
// - first_buffer_flag starts a new frame
// - frame options taken only from first descriptor
// - skip_crc_append drops CRC, whether or not padding is inserted
// - padding clear pads short frames; CRC still follows skip_crc_append
// - tx_stamp_request on first asks for timestamp
// - crc_overwrite with skip_crc replaces last four bytes
// - checksum_offload_sel picks checksum insertion mode
// - ring_wrap_flag returns to list base address
// - chained_next_ptr uses second address as next
// - ring wrap wins over chaining
// - vlan_tag_action picks none, strip, insert, replace
// - last descriptor reports captured stamp, words 2-3
// - error_rollup is OR of the error bits
`timescale 1ns/10ps
`include "etd0_params.svh"
module etd0_top #(
   parameter int ADDR_W = 8
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic fetch_valid,
   input wire logic fetch_ready,
   output logic [31:0] fetch_addr,
   input wire logic desc_valid,
   output logic desc_ready,
   input wire etd0_pkg::etd0_desc_type desc,
   output logic seg_valid,
   input wire logic seg_ready,
   output etd0_pkg::etd0_seg_type seg,
   output etd0_pkg::etd0_frame_ctl_type frame_ctl,
   input wire logic seg_done,
   input wire logic done_valid,
   output logic done_ready,
   input wire etd0_pkg::etd0_done_type done,
   output logic wb_valid,
   input wire logic wb_ready,
   output etd0_pkg::etd0_wb_type wb,
   output logic tx_irq_status
);
   import etd0_pkg::*;

   etd0_state_type state;
   logic run;
   logic poll;
   logic unavail;
   logic [31:0] base;
   logic [31:0] cur;
   logic [31:0] word0;
   logic [31:0] addr2;
   logic aw_got;
   logic w_got;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire;
   logic wr_ctrl;
   logic wr_base;
   logic wr_stat;
   logic wr_hit;
   logic [31:0] ctrl_new;
   logic set_unavail;
   logic set_irq;
   logic [31:0] next_word0;
   logic [31:0] next_cur;

   function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] val,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = val[i*8 +: 8];
         end
      end
      return res;
   endfunction : strb_merge

   function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      return a == ADDR_W'(ofs);
   endfunction : is_reg

   // ---------------- register bus ----------------
   assign s_axi_awready = !aw_got && !s_axi_bvalid;
   assign s_axi_wready = !w_got && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_fire = aw_got && w_got && !s_axi_bvalid;
   assign wr_ctrl = wr_fire && is_reg(aw_addr, `ETD0_OFS_CTRL);
   assign wr_base = wr_fire && is_reg(aw_addr, `ETD0_OFS_BASE);
   assign wr_stat = wr_fire && is_reg(aw_addr, `ETD0_OFS_STAT);
   assign wr_hit = wr_ctrl || wr_base || wr_stat || is_reg(aw_addr, `ETD0_OFS_CUR);
   assign ctrl_new = strb_merge({30'h0000_0000, 1'b0, run}, w_data, w_strb);

   always_ff @(posedge mclk) begin
      if (srst) begin
         aw_got <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_got <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_got <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         w_got <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_got <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_got <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ETD0_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? `ETD0_RESP_OKAY : `ETD0_RESP_DECERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `ETD0_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `ETD0_RESP_OKAY;
         if (is_reg(s_axi_araddr, `ETD0_OFS_CTRL)) begin
            s_axi_rdata <= {31'h0000_0000, run};
         end else if (is_reg(s_axi_araddr, `ETD0_OFS_BASE)) begin
            s_axi_rdata <= base;
         end else if (is_reg(s_axi_araddr, `ETD0_OFS_STAT)) begin
            s_axi_rdata <= {16'h0000, state, 6'h00, unavail, tx_irq_status};
         end else if (is_reg(s_axi_araddr, `ETD0_OFS_CUR)) begin
            s_axi_rdata <= cur;
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ETD0_RESP_DECERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         run <= 1'b0;
         poll <= 1'b0;
      end else begin
         poll <= wr_ctrl && ctrl_new[`ETD0_CTRL_POLL];
         if (wr_ctrl) begin
            run <= ctrl_new[`ETD0_CTRL_RUN];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         base <= `ETD0_BASE_RST;
      end else if (wr_base) begin
         base <= strb_merge(base, w_data, w_strb);
      end
   end

   // write-one-to-clear; a set in the same cycle wins
   always_ff @(posedge mclk) begin
      if (srst) begin
         tx_irq_status <= 1'b0;
         unavail <= 1'b0;
      end else begin
         if (set_irq) begin
            tx_irq_status <= 1'b1;
         end else if (wr_stat && w_strb[0] && w_data[`ETD0_STAT_TXIRQ]) begin
            tx_irq_status <= 1'b0;
         end
         if (set_unavail) begin
            unavail <= 1'b1;
         end else if (wr_stat && w_strb[0] && w_data[`ETD0_STAT_UNAVAIL]) begin
            unavail <= 1'b0;
         end
      end
   end

   // ---------------- descriptor engine ----------------
   assign fetch_valid = state == ST_FETCH;
   assign fetch_addr = cur;
   assign desc_ready = state == ST_DESC;
   assign seg_valid = state == ST_SEG;
   assign done_ready = state == ST_FRAME;
   assign wb_valid = state == ST_WB;
   assign set_unavail = desc_ready && desc_valid && !desc[0][`ETD0_B_OWN];
   assign set_irq = done_ready && done_valid && word0[`ETD0_B_LAST] && word0[`ETD0_B_IRQ];

   // status and own travel in one word so software never sees half an update
   always_comb begin
      next_word0 = word0 & ~`ETD0_STATUS_MASK;
      next_word0[`ETD0_B_OWN] = 1'b0;
      if (word0[`ETD0_B_LAST]) begin
         next_word0 = next_word0 | (done.status & `ETD0_STATUS_MASK);
         next_word0[`ETD0_B_STAMPED] = done.stamp_valid;
         next_word0[`ETD0_B_ERRSUM] = |(done.status & `ETD0_ERR_MASK);
      end
   end

   always_comb begin
      if (word0[`ETD0_B_WRAP]) begin
         next_cur = base;
      end else if (word0[`ETD0_B_CHAIN]) begin
         next_cur = addr2;
      end else begin
         next_cur = cur + `ETD0_DESC_BYTES;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (run) begin
                  state <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               if (fetch_ready) begin
                  state <= ST_DESC;
               end
            end
            ST_DESC: begin
               if (desc_valid) begin
                  state <= desc[0][`ETD0_B_OWN] ? ST_SEG : ST_SUSPEND;
               end
            end
            ST_SEG: begin
               if (seg_ready) begin
                  state <= ST_DRAIN;
               end
            end
            ST_DRAIN: begin
               if (seg_done) begin
                  state <= word0[`ETD0_B_LAST] ? ST_FRAME : ST_WB;
               end
            end
            ST_FRAME: begin
               if (done_valid) begin
                  state <= ST_WB;
               end
            end
            ST_WB: begin
               if (wb_ready) begin
                  state <= ST_IDLE;
               end
            end
            ST_SUSPEND: begin
               if (poll || !run) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // list pointer restarts at base on every run start
   always_ff @(posedge mclk) begin
      if (srst) begin
         cur <= `ETD0_BASE_RST;
      end else if (wr_ctrl && ctrl_new[`ETD0_CTRL_RUN] && !run) begin
         cur <= base;
      end else if (wb_valid && wb_ready) begin
         cur <= next_cur;
      end
   end

   // all eight words arrive in one beat; only 0..3 steer this engine
   always_ff @(posedge mclk) begin
      if (srst) begin
         word0 <= 32'h0000_0000;
         addr2 <= 32'h0000_0000;
         seg <= '0;
      end else if (desc_ready && desc_valid) begin
         word0 <= desc[0];
         addr2 <= desc[3];
         seg.first <= desc[0][`ETD0_B_FIRST];
         seg.last <= desc[0][`ETD0_B_LAST];
         seg.buf1_addr <= desc[2];
         seg.buf1_size <= desc[1][`ETD0_F_SIZE1_HI:0];
         seg.buf2_addr <= desc[0][`ETD0_B_CHAIN] ? 32'h0000_0000 : desc[3];
         seg.buf2_size <= desc[0][`ETD0_B_CHAIN] ? 13'h0000 : desc[1][`ETD0_F_SIZE2_HI:`ETD0_F_SIZE2_LO];
      end
   end

   // frame options held from the first segment for the whole frame
   always_ff @(posedge mclk) begin
      if (srst) begin
         frame_ctl <= '0;
      end else if (desc_ready && desc_valid && desc[0][`ETD0_B_OWN] && desc[0][`ETD0_B_FIRST]) begin
         frame_ctl.append_crc <= !desc[0][`ETD0_B_NOCRC];
         frame_ctl.pad_enable <= !desc[0][`ETD0_B_NOPAD];
         frame_ctl.crc_replace <= desc[0][`ETD0_B_CRCOVR] && desc[0][`ETD0_B_NOCRC];
         frame_ctl.stamp_req <= desc[0][`ETD0_B_STAMP];
         frame_ctl.csum_sel <= desc[0][`ETD0_F_CSUM_HI:`ETD0_F_CSUM_LO];
         frame_ctl.vlan_action <= desc[0][`ETD0_F_VLAN_HI:`ETD0_F_VLAN_LO];
      end
   end

   // write-back image; a non-last descriptor carries no stamp
   always_ff @(posedge mclk) begin
      if (srst) begin
         wb <= '0;
      end else if ((state == ST_DRAIN && seg_done && !word0[`ETD0_B_LAST]) || (done_ready && done_valid)) begin
         wb.addr <= cur;
         wb.word0 <= next_word0;
         wb.stamp_en <= word0[`ETD0_B_LAST] && done.stamp_valid;
         wb.word2 <= done.stamp[31:0];
         wb.word3 <= done.stamp[63:32];
      end
   end
endmodule : etd0_top

// ===== tb/etd0_tb_asserts.sv
// port assertions of the descriptor engine
`timescale 1ns/10ps
module etd0_asserts (
   input wire logic mclk,
   input wire logic srst,
   input wire logic fetch_valid,
   input wire logic fetch_ready,
   input wire logic desc_valid,
   input wire logic desc_ready,
   input wire etd0_pkg::etd0_desc_type desc,
   input wire logic seg_valid,
   input wire etd0_pkg::etd0_frame_ctl_type frame_ctl,
   input wire logic wb_valid,
   input wire etd0_pkg::etd0_wb_type wb,
   input wire logic tx_irq_status
);
   logic [31:0] w0;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);
   // word0 of the descriptor taken one edge earlier
   always_ff @(posedge mclk) w0 <= desc[0];
   sequence s_take; desc_valid && desc_ready; endsequence
   sequence s_own; s_take ##0 desc[0][31]; endsequence
   property p_go; s_own |=> seg_valid; endproperty
   property p_stop; s_take ##0 !desc[0][31] |=> !seg_valid [*3]; endproperty
   property p_opt;
      s_own ##0 desc[0][28] |=> frame_ctl == {~w0[27], ~w0[26], w0[24] & w0[27], w0[25], w0[23:22], w0[19:18]};
   endproperty
   property p_hold; s_own ##0 !desc[0][28] |=> $stable(frame_ctl); endproperty
   property p_own; wb_valid |-> !wb.word0[31]; endproperty
   property p_err; wb_valid |-> wb.word0[15] == |(wb.word0 & 32'h0001_7f06); endproperty
   property p_irq; wb_valid && wb.word0[30] && wb.word0[29] |-> tx_irq_status; endproperty
   property p_stamp; wb_valid && wb.word0[29] |-> wb.word0[17] == wb.stamp_en; endproperty
   property p_fetch; fetch_valid && fetch_ready |=> desc_ready; endproperty
   a_go: assert property (p_go) else $error("owned descriptor stalled");
   a_stop: assert property (p_stop) else $error("host descriptor used");
   a_opt: assert property (p_opt) else $error("frame options wrong");
   a_hold: assert property (p_hold) else $error("options changed mid frame");
   a_own: assert property (p_own) else $error("own bit kept");
   a_err: assert property (p_err) else $error("error summary wrong");
   a_irq: assert property (p_irq) else $error("irq status missing");
   a_stamp: assert property (p_stamp) else $error("stamp flag wrong");
   a_fetch: assert property (p_fetch) else $error("descriptor not taken");
endmodule : etd0_asserts
bind etd0_top etd0_asserts u_chk (.mclk, .srst, .fetch_valid, .fetch_ready, .desc_valid, .desc_ready, .desc,
   .seg_valid, .frame_ctl, .wb_valid, .wb, .tx_irq_status);

// ===== tb/etd0_mem_model.sv
// descriptor memory and far side of the descriptor engine
`timescale 1ns/10ps
module etd0_mem_model (
   input wire logic mclk,
   input wire logic srst,
   input wire logic slow,
   input wire logic fetch_valid,
   output logic fetch_ready,
   input wire logic [31:0] fetch_addr,
   output logic desc_valid,
   input wire logic desc_ready,
   output etd0_pkg::etd0_desc_type desc,
   input wire logic seg_valid,
   output logic seg_ready,
   input wire etd0_pkg::etd0_seg_type seg,
   output logic seg_done,
   output logic done_valid,
   input wire logic done_ready,
   output etd0_pkg::etd0_done_type done,
   input wire logic wb_valid,
   output logic wb_ready,
   input wire etd0_pkg::etd0_wb_type wb
);
   import etd0_pkg::*;
   logic [31:0] mem [0:255];
   logic tick, lst;
   logic [2:0] cnt;
   etd0_done_type nd;
   initial {fetch_ready, desc_valid, seg_ready, seg_done, done_valid, wb_ready, desc, done} = '0;
   // slow mode stalls every other cycle and stretches the drain
   always @(posedge mclk) begin
      seg_done <= 1'b0;
      if (srst) begin
         {tick, fetch_ready, desc_valid, seg_ready, done_valid, wb_ready, cnt} <= '0;
      end else begin
         tick <= ~tick;
         {fetch_ready, seg_ready, wb_ready} <= {3{~slow | tick}};
         if (fetch_valid && fetch_ready) begin
            desc_valid <= 1'b1;
            for (int k = 0; k < 8; k++) begin
               desc[k] <= mem[8'(fetch_addr[9:2] + k)];
            end
         end
         if (desc_valid && desc_ready) begin
            desc_valid <= 1'b0;
            desc <= ~desc;
            // test status and stamp travel in the spare words 6 and 7
            nd <= {desc[7], desc[6][0], desc[6], desc[7]};
         end
         if (seg_valid && seg_ready) begin
            cnt <= slow ? 3'h5 : 3'h1;
            lst <= seg.last;
         end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
            if (cnt == 3'h1) begin
               seg_done <= 1'b1;
               done_valid <= lst;
               done <= nd;
            end
         end
         if (done_valid && done_ready) begin
            done_valid <= 1'b0;
            done <= ~done;
         end
         if (wb_valid && wb_ready) begin
            mem[wb.addr[9:2]] <= wb.word0;
         end
      end
   end
endmodule : etd0_mem_model

// ===== tb/testbench.sv
// self-checking bench of the descriptor engine
`timescale 1ns/10ps
module testbench;
   import etd0_pkg::*;
   logic mclk, srst, slow, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, fetch_addr, r, d;
   logic [1:0] s_axi_bresp, s_axi_rresp, br;
   logic [3:0] s_axi_wstrb;
   logic fetch_valid, fetch_ready, desc_valid, desc_ready, seg_valid, seg_ready, seg_done;
   logic done_valid, done_ready, wb_valid, wb_ready, tx_irq_status, ei;
   etd0_desc_type desc;
   etd0_seg_type seg;
   etd0_frame_ctl_type frame_ctl;
   etd0_done_type done;
   etd0_wb_type wb;
   int failures, n_checks, fi, si, wi;
   logic [31:0] ea [0:7], w0 [0:7], w1 [0:7], w6 [0:7], w7 [0:7];
   etd0_top u_dut (.mclk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fetch_valid, .fetch_ready,
      .fetch_addr, .desc_valid, .desc_ready, .desc, .seg_valid, .seg_ready, .seg, .frame_ctl, .seg_done,
      .done_valid, .done_ready, .done, .wb_valid, .wb_ready, .wb, .tx_irq_status);
   etd0_mem_model u_mem (.mclk, .srst, .slow, .fetch_valid, .fetch_ready, .fetch_addr, .desc_valid, .desc_ready,
      .desc, .seg_valid, .seg_ready, .seg, .seg_done, .done_valid, .done_ready, .done, .wb_valid, .wb_ready, .wb);
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   function automatic logic [31:0] lf(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lf
   function automatic logic [31:0] exw(input int i);
      logic [31:0] x;
      x = w0[i] & 32'h7ffe_0000;
      if (w0[i][29]) begin
         x = x | (w7[i] & 32'h0001_ffff);
         x[17] = w6[i][0];
      end
      x[15] = |(x & 32'h0001_7f06);
      return x;
   endfunction : exw
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      n_checks++;
      if (g !== x) begin
         failures++;
         $display("BAD t=%0t got %h exp %h", $time, g, x);
      end
   endtask : chk
   task automatic wrap_up();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up
   task automatic axw(input logic [7:0] a, input logic [31:0] x);
      {s_axi_awaddr, s_axi_wdata} <= {a, x};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      br = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge mclk);
   endtask : axw
   task automatic axr(input logic [7:0] a);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge mclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      {d, br} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
      @(posedge mclk);
   endtask : axr
   always @(posedge mclk) begin
      if (!srst && fetch_valid && fetch_ready) begin
         chk(fetch_addr, ea[fi]);
         fi++;
      end
      if (!srst && seg_valid && seg_ready) begin
         chk({4'h0, seg.first, seg.last, seg.buf1_size, seg.buf2_size}, {4'h0, w0[si][28], w0[si][29],
            w1[si][12:0], w0[si][20] ? 13'h0 : w1[si][28:16]});
         chk(seg.buf1_addr, ~w7[si]);
         chk(seg.buf2_addr, w0[si][20] ? 32'h0 : ea[si + 1]);
         si++;
      end
      if (!srst && wb_valid && wb_ready) begin
         chk(wb.word0, exw(wi));
         chk(wb.addr, ea[wi]);
         if (w0[wi][29] & w6[wi][0]) begin
            chk({wb.word3, wb.word2} == {w6[wi], w7[wi]}, 32'h1);
         end
         wi++;
      end
   end
   initial begin
      #400000;
      failures++;
      wrap_up();
   end
   initial begin
      {srst, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h40;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hf};
      r = 32'h30301cc7;
      repeat (10) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      axw(8'h10, r);
      chk({30'h0, br}, 32'h3);
      axw(8'h0c, r);
      for (int k = 0; k < 5; k++) begin
         axr(8'(k * 4));
         chk(d, k == 2 ? 32'h100 : 32'h0);
         chk({30'h0, br}, k == 4 ? 32'h3 : 32'h0);
      end
      for (int p = 0; p < 2; p++) begin
         slow <= p[0];
         ei = 1'b0;
         {fi, si, wi} = '0;
         ea[0] = 32'(p) * 32'h200;
         for (int i = 0; i < 6; i++) begin
            r = lf(r);
            w0[i] = (r & 32'h7fcf_ffff) | 32'h8000_0000;
            w0[i][21] = (i == 5);
            w0[i][20] = !i[0] || i == 5;
            r = lf(r);
            w1[i] = (r & 32'h1fff_1fff) | 32'h1;
            ea[i + 1] = ea[i] + (w0[i][20] ? 32'h60 : 32'h20);
            w6[i] = lf(r);
            w7[i] = ~r;
            ei = ei | (w0[i][30] & w0[i][29]);
            for (int k = 0; k < 8; k++) begin
               u_mem.mem[8'(ea[i][9:2] + k)] = k == 0 ? w0[i] : k == 1 ? w1[i] : k == 3 ? ea[i + 1] :
                  k == 6 ? w6[i] : k == 7 ? w7[i] : r;
            end
         end
         // last entry chains to a decoy, the wrap must win and meet a released descriptor
         ea[6] = ea[0];
         ea[7] = ea[0];
         axw(8'h04, ea[0]);
         axw(8'h00, 32'h1);
         do axr(8'h08); while (d[15:8] !== 8'h80);
         chk(d & 32'h0000_ff03, {16'h0, 8'h80, 6'h0, 1'b1, ei});
         chk(fi, 32'd7);
         chk(wi, 32'd6);
         // poll retries the released head once and must stop there again
         axw(8'h00, 32'h3);
         do axr(8'h08); while (d[15:8] !== 8'h80);
         chk(fi, 32'd8);
         chk(wi, 32'd6);
         axw(8'h08, 32'h3);
         axr(8'h08);
         chk({d[1:0], tx_irq_status}, 32'h0);
         axw(8'h00, 32'h0);
      end
      wrap_up();
   end
endmodule : testbench
